/* rtl/isr_pkg.sv */
// Purpose: constants and types for the sub-addressed i2c slave register map
// Assumes: 7-bit addressing, big-endian multi-byte registers
// Notes: supported data window length ceiling is a design figure
package isr_pkg;
    // sub-addresses
    localparam logic [7:0] SUB_DATA = 8'h80;
    localparam logic [7:0] SUB_DLEN = 8'h81;
    localparam logic [7:0] SUB_STATE = 8'h82;
    localparam logic [7:0] SUB_BADDR = 8'h83;
    localparam logic [7:0] SUB_MAXCLK = 8'h84;
    localparam logic [7:0] SUB_GUARD = 8'h85;
    // register sizes in bytes
    localparam logic [2:0] SZ_DLEN = 3'h2;
    localparam logic [2:0] SZ_WORD = 3'h4;
    // reset values and limits
    localparam logic [6:0] ADDR_RST = 7'h20;
    localparam logic [15:0] DLEN_MIN = 16'h0010;
    localparam logic [15:0] DLEN_MAX_SUP = 16'h0100;
    localparam logic [15:0] DLEN_RST = DLEN_MAX_SUP;
    localparam logic [15:0] PKT_OVERHEAD = 16'h0005;
    localparam logic [15:0] MPS_RST = DLEN_RST - PKT_OVERHEAD;
    localparam logic [31:0] KHZ_FLOOR = 32'h0000_0032;
    localparam logic [31:0] KHZ_FAST = 32'h0000_0190;
    localparam logic [31:0] KHZ_FAST_PLUS = 32'h0000_03E8;
    localparam logic [31:0] GUARD_UNSUP = 32'hFFFF_FFFF;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    // state word fields
    localparam int ST_BUSY_BIT = 31;
    localparam int ST_RESP_BIT = 30;
    localparam int ST_STRETCH_BIT = 29;
    localparam logic STRETCH_SUPPORTED = 1'b0;
    // buffering and link states
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 16;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_TACK = 3'b100
    } isr_state_t;
endpackage

/* rtl/isr_slave.sv */
// Purpose: i2c slave register map with a data window and streaming fifos
// Assumes: LINK_CLK oversamples SCL/SDA; no clock stretching
// Notes: fifos carry the data window between link and core domains
//
// Contract
// RULE1: data window at 0x80, read and write
// RULE2: window length is 16 bits, 0x0010..0xFFFF
// RULE3: new window length applies from next access
// RULE4: unsupported length stores largest supported length
// RULE5: max packet size equals length minus five
// RULE6: state top byte: features, busy, response ready
// RULE7: state low half gives pending response length
// RULE8: address register write-only; reset address 0x20
// RULE9: new address takes effect after access ends
// RULE10: bits 6:0 address; bit 15 makes persistent
// RULE11: 0x84 reports max clock, follows speed mode
// RULE12: fast class reports 50 to 400 kHz
// RULE13: fast plus class reports 50 to 1000
// RULE14: unimplemented guard time reads all ones
// RULE15: multi-byte values travel high byte first
// RULE16: reads past end or unmapped give 0xFF
// RULE17: writes to read-only registers are ignored
`timescale 1ns/1ps
module isr_afifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // write side
    input wire logic wclk,
    input wire logic wrst_n,
    input wire logic w_valid,
    output logic w_ready,
    input wire logic [W-1:0] w_data,
    // read side
    input wire logic rclk,
    input wire logic rrst_n,
    output logic r_valid,
    input wire logic r_ready,
    output logic [W-1:0] r_data,
    output logic [$clog2(DEPTH):0] r_count
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
    logic [AW:0] rg1_q, rg2_q, wg1_q, wg2_q;
    logic [AW:0] wbin_d, rbin_d;

    function automatic logic [AW:0] g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int k = AW - 1; k >= 0; k--)
        begin
            b[k] = b[k+1] ^ g[k];
        end
        return b;
    endfunction

    assign w_ready = (wgray_q != {~rg2_q[AW:AW-1], rg2_q[AW-2:0]});
    assign r_valid = (rgray_q != wg2_q);
    assign r_data = mem[rbin_q[AW-1:0]];
    assign r_count = g2b(wg2_q) - rbin_q;
    assign wbin_d = wbin_q + (AW+1)'(w_valid && w_ready);
    assign rbin_d = rbin_q + (AW+1)'(r_valid && r_ready);

    always_ff @(posedge wclk)
    begin
        if (w_valid && w_ready)
            mem[wbin_q[AW-1:0]] <= w_data;
    end

    // gray pointers cross; the first stage feeds only the second
    always_ff @(posedge wclk or negedge wrst_n)
    begin
        if (!wrst_n)
        begin
            wbin_q <= '0;
            wgray_q <= '0;
            rg1_q <= '0;
            rg2_q <= '0;
        end
        else
        begin
            wbin_q <= wbin_d;
            wgray_q <= wbin_d ^ (wbin_d >> 1);
            rg1_q <= rgray_q;
            rg2_q <= rg1_q;
        end
    end

    always_ff @(posedge rclk or negedge rrst_n)
    begin
        if (!rrst_n)
        begin
            rbin_q <= '0;
            rgray_q <= '0;
            wg1_q <= '0;
            wg2_q <= '0;
        end
        else
        begin
            rbin_q <= rbin_d;
            rgray_q <= rbin_d ^ (rbin_d >> 1);
            wg1_q <= wgray_q;
            wg2_q <= wg1_q;
        end
    end
endmodule

module isr_slave (
    // core clock and resets
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic POR_N,
    // i2c link
    input wire logic LINK_CLK,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    // data written by the master
    output logic [isr_pkg::BYTE_W-1:0] RX_DATA,
    output logic RX_VALID,
    input wire logic RX_READY,
    // response data for the master
    input wire logic [isr_pkg::BYTE_W-1:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    // status and configuration
    input wire logic CMD_BUSY,
    input wire logic FAST_PLUS_SPEED_CLASS,
    output logic [15:0] MAX_PACKET_SIZE
);
    import isr_pkg::*;

    logic lrst1_q, lrst_n;
    logic scl1_q, scl2_q, scl_d_q, sda1_q, sda2_q, sda_d_q;
    logic busy1_q, busy2_q, fp1_q, fp2_q;
    logic start, stop, rise, fall, byte_done;
    isr_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, tx_q, sub_q, hold_q, rd_byte;
    logic first_q, sub_next_q, rw_q, nack_q, low_q, load, wr_ok;
    logic [15:0] idx_q, dwl_q, dwl_act_q, mps_q, dlen_new;
    logic [6:0] addr_q, addr_pend_q, persist_q;
    logic loaded_q, mps_tog_q, tog1_q, tog2_q, tog3_q;
    logic rx_push, rx_ok, tx_avail, tx_pop;
    logic [7:0] tx_rd;
    logic [$clog2(FIFO_DEPTH):0] tx_cnt;
    logic [31:0] state_word, max_khz;

    function automatic logic [7:0] pick(input logic [31:0] v, input logic [2:0] n,
                                        input logic [15:0] i);
        logic [4:0] s;
        s = {2'(n - 3'h1 - i[2:0]), 3'h0};
        return (i >= 16'(n)) ? FILL_BYTE : v[s +: 8];
    endfunction

    // link reset: asserted at once, released on the link clock
    always_ff @(posedge LINK_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            lrst1_q <= 1'b0;
            lrst_n <= 1'b0;
        end
        else
        begin
            lrst1_q <= 1'b1;
            lrst_n <= lrst1_q;
        end
    end

    always_ff @(posedge LINK_CLK or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            {scl1_q, scl2_q, scl_d_q, sda1_q, sda2_q, sda_d_q} <= 6'h3F;
            {busy1_q, busy2_q, fp1_q, fp2_q} <= 4'h0;
        end
        else
        begin
            {scl1_q, scl2_q, scl_d_q} <= {SCL_I, scl1_q, scl2_q};
            {sda1_q, sda2_q, sda_d_q} <= {SDA_I, sda1_q, sda2_q};
            {busy1_q, busy2_q} <= {CMD_BUSY, busy1_q};
            {fp1_q, fp2_q} <= {FAST_PLUS_SPEED_CLASS, fp1_q};
        end
    end

    assign start = scl2_q && scl_d_q && sda_d_q && !sda2_q;
    assign stop = scl2_q && scl_d_q && !sda_d_q && sda2_q;
    assign rise = scl2_q && !scl_d_q;
    assign fall = !scl2_q && scl_d_q;
    assign byte_done = fall && state_q == ST_RX && cnt_q == 4'h8;
    assign load = fall && rw_q && ((state_q == ST_ACK) || (state_q == ST_TACK && !nack_q));

    // speed class only moves the ceiling; both stay above the floor
    assign max_khz = fp2_q ? KHZ_FAST_PLUS : KHZ_FAST; // [RULE11] [RULE12] [RULE13]
    assign state_word = {busy2_q, tx_avail, STRETCH_SUPPORTED, 13'h0000,
                         16'(tx_cnt)}; // [RULE6] [RULE7]

    always_comb
    begin
        case (sub_q)
            SUB_DATA: rd_byte = (idx_q < dwl_act_q && tx_avail) ? tx_rd : FILL_BYTE; // [RULE1]
            SUB_DLEN: rd_byte = pick({16'h0000, dwl_q}, SZ_DLEN, idx_q); // [RULE15]
            SUB_STATE: rd_byte = pick(state_word, SZ_WORD, idx_q);
            SUB_MAXCLK: rd_byte = pick(max_khz, SZ_WORD, idx_q); // [RULE11]
            SUB_GUARD: rd_byte = pick(GUARD_UNSUP, SZ_WORD, idx_q); // [RULE14]
            default: rd_byte = FILL_BYTE; // [RULE16]
        endcase
    end

    assign tx_pop = load && sub_q == SUB_DATA && idx_q < dwl_act_q && tx_avail;
    // a full receive fifo refuses the byte with a nack
    assign wr_ok = !(sub_q == SUB_DATA) || (idx_q < dwl_act_q && rx_ok);
    assign rx_push = byte_done && !first_q && !sub_next_q && sub_q == SUB_DATA && wr_ok;
    assign dlen_new = {hold_q, sh_q};

    // bit and byte sequencing
    always_ff @(posedge LINK_CLK or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            low_q <= 1'b0;
            nack_q <= 1'b0;
            first_q <= 1'b0;
            sub_next_q <= 1'b0;
            rw_q <= 1'b0;
        end
        else if (start)
        begin
            state_q <= ST_RX;
            cnt_q <= 4'h0;
            low_q <= 1'b0;
            first_q <= 1'b1;
        end
        else if (stop)
        begin
            state_q <= ST_IDLE;
            low_q <= 1'b0;
        end
        else if (load)
        begin
            state_q <= ST_TX;
            tx_q <= rd_byte;
            low_q <= !rd_byte[7];
            cnt_q <= 4'h1;
        end
        else
        begin
            case (state_q)
                ST_RX:
                begin
                    if (rise && cnt_q < 4'h8)
                    begin
                        sh_q <= {sh_q[6:0], sda2_q};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (byte_done)
                    begin
                        first_q <= 1'b0;
                        if (first_q)
                        begin
                            rw_q <= sh_q[0];
                            sub_next_q <= !sh_q[0];
                        end
                        else
                            sub_next_q <= 1'b0;
                        if (first_q && sh_q[7:1] != addr_q)
                            state_q <= ST_IDLE;
                        else
                        begin
                            state_q <= ST_ACK;
                            low_q <= first_q || sub_next_q || wr_ok;
                        end
                    end
                end
                ST_ACK:
                begin
                    if (fall)
                    begin
                        low_q <= 1'b0;
                        state_q <= ST_RX;
                        cnt_q <= 4'h0;
                    end
                end
                ST_TX:
                begin
                    if (fall)
                    begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        low_q <= (cnt_q == 4'h8) ? 1'b0 : !tx_q[6];
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'h8)
                            state_q <= ST_TACK;
                    end
                end
                ST_TACK:
                begin
                    if (rise)
                        nack_q <= sda2_q;
                    if (fall)
                        state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // sub-address and byte index
    always_ff @(posedge LINK_CLK or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            sub_q <= 8'hFF;
            idx_q <= 16'h0000;
            hold_q <= 8'h00;
        end
        else if (start)
            idx_q <= 16'h0000;
        else if (byte_done && !first_q && sub_next_q)
        begin
            sub_q <= sh_q;
            idx_q <= 16'h0000;
        end
        else if ((byte_done && !first_q) || load)
        begin
            idx_q <= idx_q + 16'h0001;
            if (idx_q == 16'h0000)
                hold_q <= sh_q;
        end
    end

    // window length: stored now, applied at the next start
    always_ff @(posedge LINK_CLK or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            dwl_q <= DLEN_RST;
            dwl_act_q <= DLEN_RST;
            mps_q <= MPS_RST;
            mps_tog_q <= 1'b0;
        end
        else
        begin
            if (byte_done && !first_q && !sub_next_q && sub_q == SUB_DLEN
                && idx_q == 16'h0001)
                dwl_q <= (dlen_new >= DLEN_MIN && dlen_new <= DLEN_MAX_SUP) ?
                         dlen_new : DLEN_MAX_SUP; // [RULE2] [RULE4] [RULE17]
            if (start)
                dwl_act_q <= dwl_q; // [RULE3]
            if (dwl_act_q - PKT_OVERHEAD != mps_q)
            begin
                mps_q <= dwl_act_q - PKT_OVERHEAD; // [RULE5]
                mps_tog_q <= !mps_tog_q;
            end
        end
    end

    // persistent default survives RST_N, cleared only by power-on
    always_ff @(posedge LINK_CLK or negedge POR_N)
    begin
        if (!POR_N)
            persist_q <= ADDR_RST; // [RULE8]
        else if (byte_done && !first_q && !sub_next_q && sub_q == SUB_BADDR
                 && idx_q == 16'h0001 && hold_q[7])
            persist_q <= sh_q[6:0]; // [RULE10]
    end

    always_ff @(posedge LINK_CLK or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            addr_q <= ADDR_RST;
            addr_pend_q <= ADDR_RST;
            loaded_q <= 1'b0;
        end
        else if (!loaded_q)
        begin
            addr_q <= persist_q;
            addr_pend_q <= persist_q;
            loaded_q <= 1'b1;
        end
        else
        begin
            if (byte_done && !first_q && !sub_next_q && sub_q == SUB_BADDR
                && idx_q == 16'h0001)
                addr_pend_q <= sh_q[6:0]; // [RULE10]
            if (stop)
                addr_q <= addr_pend_q; // [RULE9]
        end
    end

    // packet size crosses by toggle; the value changes on the same link edge and holds while the toggle syncs
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            {tog1_q, tog2_q, tog3_q} <= 3'h0;
            MAX_PACKET_SIZE <= MPS_RST;
        end
        else
        begin
            {tog1_q, tog2_q, tog3_q} <= {mps_tog_q, tog1_q, tog2_q};
            if (tog2_q != tog3_q)
                MAX_PACKET_SIZE <= mps_q; // [RULE5]
        end
    end

    assign SDA_O = 1'b0;
    assign SDA_OE = low_q;

    isr_afifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rxf (
        .wclk(LINK_CLK), .wrst_n(lrst_n), .w_valid(rx_push), .w_ready(rx_ok),
        .w_data(sh_q), .rclk(CORE_CLK), .rrst_n(RST_N), .r_valid(RX_VALID),
        .r_ready(RX_READY), .r_data(RX_DATA), .r_count()
    );
    isr_afifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_txf (
        .wclk(CORE_CLK), .wrst_n(RST_N), .w_valid(TX_VALID), .w_ready(TX_READY),
        .w_data(TX_DATA), .rclk(LINK_CLK), .rrst_n(lrst_n), .r_valid(tx_avail),
        .r_ready(tx_pop), .r_data(tx_rd), .r_count(tx_cnt)
    );

    a_push_window: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // [RULE1]
        rx_push |-> sub_q == SUB_DATA && idx_q < dwl_act_q)
        else $error("push outside data window");
    a_len_range: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // [RULE4]
        dwl_q >= DLEN_MIN && dwl_q <= DLEN_MAX_SUP)
        else $error("window length out of range");
    a_len_defer: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // [RULE3]
        $changed(dwl_act_q) |-> $past(start))
        else $error("window length applied mid access");
    a_pkt_size: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // [RULE5]
        $changed(dwl_act_q) |=> mps_q == dwl_act_q - PKT_OVERHEAD && $changed(mps_tog_q))
        else $error("packet size not length minus five");
    a_state_flags: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // [RULE6]
        state_word[ST_BUSY_BIT] == busy2_q && state_word[ST_RESP_BIT] == tx_avail)
        else $error("state flags wrong");
    a_resp_len: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // [RULE7]
        state_word[15:0] == 16'(tx_cnt) && (tx_avail == (tx_cnt != '0)))
        else $error("response length wrong");
    a_addr_switch: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // [RULE9]
        $changed(addr_q) && $past(loaded_q) |-> $past(stop))
        else $error("address changed inside access");
    a_max_clock: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // [RULE12]
        max_khz >= KHZ_FLOOR && max_khz <= (fp2_q ? KHZ_FAST_PLUS : KHZ_FAST))
        else $error("max clock out of range");
    a_fill_byte: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // [RULE16]
        load && sub_q != SUB_DATA && (sub_q < SUB_DATA || sub_q > SUB_GUARD
        || sub_q == SUB_BADDR || idx_q >= 16'h0004) |=> tx_q == FILL_BYTE)
        else $error("fill byte not 0xFF");
    a_ro_ignore: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // [RULE17]
        byte_done && (sub_q == SUB_STATE || sub_q == SUB_MAXCLK) |=> $stable(dwl_q)
        && $stable(addr_pend_q))
        else $error("read-only write changed state");
    c_read_byte: cover property (@(posedge LINK_CLK) disable iff (!lrst_n) tx_pop);
    c_write_byte: cover property (@(posedge LINK_CLK) disable iff (!lrst_n) rx_push);
    c_new_addr: cover property (@(posedge LINK_CLK) disable iff (!lrst_n)
        loaded_q && $changed(addr_q));
endmodule

/* verification/isr_i2c_master.sv */
// Purpose: bus master model that drives the slave's i2c pins
// Assumes: sda has a pull-up; this master alone drives scl
// Notes: timing counted in core clock falling edges; scl rests high between frames
`timescale 1ns/1ps
module isr_i2c_master #(
    parameter int HALF = 66
) (
    // timing reference
    input wire logic clk,
    // bus lines
    output logic scl,
    output logic sda,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe
);
    logic pull_low;
    // a released line goes to the pull-up level, never keeps the last value
    assign sda = (pull_low || (dev_sda_oe && !dev_sda_o)) ? 1'b0 : 1'b1;
    initial
    begin
        scl = 1'b1;
        pull_low = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // data moves a quarter bit after scl falls, so the slave's sync sees no false start
    task automatic bit_io(input logic b, output logic r);
        wait_n(HALF / 2);
        pull_low = !b;
        wait_n(HALF - HALF / 2);
        scl = 1'b1;
        wait_n(HALF / 2);
        r = sda;
        wait_n(HALF - HALF / 2);
        scl = 1'b0;
    endtask
    task automatic gen_start();
        wait_n(HALF / 2);
        pull_low = 1'b0;
        wait_n(HALF);
        scl = 1'b1;
        wait_n(HALF);
        pull_low = 1'b1;
        wait_n(HALF);
        scl = 1'b0;
    endtask
    task automatic gen_stop();
        wait_n(HALF / 2);
        pull_low = 1'b1;
        wait_n(HALF);
        scl = 1'b1;
        wait_n(HALF);
        pull_low = 1'b0;
        wait_n(HALF);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = (r === 1'b0);
    endtask
    task automatic rd_byte(output logic [7:0] d, input logic last);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule

/* verification/i2c_slave_register_map_bench.sv */
// Purpose: self-checking bench for the sub-addressed i2c slave
// Assumes: link clock free-running at 160 ns; bus traffic via the master model
// Notes: each scenario task drives and judges on its own
`timescale 1ns/1ps
module i2c_slave_register_map_bench;
    import isr_pkg::*;
    logic core_clk, link_clk, rst_n, por_n, scl, sda, sda_o, sda_oe;
    logic rx_valid, rx_ready, tx_valid, tx_ready, cmd_busy, fast_plus;
    logic [7:0] rx_data, tx_data;
    logic [15:0] mps;
    logic [7:0] rbuf [0:19];
    logic [6:0] dev_a;
    int mismatches, cmp_count, cycles;

    isr_slave uut (
        .CORE_CLK(core_clk), .RST_N(rst_n), .POR_N(por_n), .LINK_CLK(link_clk),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .CMD_BUSY(cmd_busy), .FAST_PLUS_SPEED_CLASS(fast_plus), .MAX_PACKET_SIZE(mps)
    );
    isr_i2c_master #(.HALF(66)) mst (
        .clk(core_clk), .scl(scl), .sda(sda), .dev_sda_o(sda_o), .dev_sda_oe(sda_oe)
    );

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;
    initial
    begin
        link_clk = 1'b0;
        #37;
        forever #80 link_clk = ~link_clk;
    end

    task automatic tally_and_finish();
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard at 150000 cycles, about a fifth above the expected length of the run (about 122000 cycles)
    always @(posedge core_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 150000)
        begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0t timeout", $time);
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr2(input logic [7:0] sub, input logic [15:0] v);
        logic a0, a1, a2, a3;
        mst.gen_start();
        mst.wr_byte({dev_a, 1'b0}, a0);
        mst.wr_byte(sub, a1);
        mst.wr_byte(v[15:8], a2);
        mst.wr_byte(v[7:0], a3);
        mst.gen_stop();
        chk({28'h0, a0, a1, a2, a3}, 32'hF, "write acks");
    endtask
    task automatic rd(input logic [7:0] sub, input int n);
        logic a0, a1, a2;
        mst.gen_start();
        mst.wr_byte({dev_a, 1'b0}, a0);
        mst.wr_byte(sub, a1);
        mst.gen_start();
        mst.wr_byte({dev_a, 1'b1}, a2);
        for (int i = 0; i < n; i++)
            mst.rd_byte(rbuf[i], i == n - 1);
        mst.gen_stop();
        chk({29'h0, a0, a1, a2}, 32'h7, "read acks");
    endtask
    function automatic logic [31:0] rd_word();
        return {rbuf[0], rbuf[1], rbuf[2], rbuf[3]};
    endfunction
    task automatic probe(input logic [6:0] a, input logic exp);
        logic ack;
        mst.gen_start();
        mst.wr_byte({a, 1'b0}, ack);
        mst.gen_stop();
        chk({31'h0, ack}, {31'h0, exp}, "address ack");
    endtask
    // held fifty cycles; the link reset asserts at once, and the 200 cycles after release cover the three link edges it then needs
    task automatic pulse_reset();
        @(negedge core_clk);
        rst_n = 1'b0;
        repeat (50) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (200) @(negedge core_clk);
    endtask

    task automatic t_reset();
        chk({16'h0, mps}, {16'h0, DLEN_RST - 16'h0005}, "packet size at reset");
        chk({30'h0, rx_valid, tx_ready}, 32'h1, "fifo flags at reset");
    endtask
    task automatic t_clock_and_guard();
        rd(SUB_MAXCLK, 4);
        chk(rd_word(), 32'h0000_0190, "fast class khz");
        wr2(SUB_MAXCLK, 16'h1234);
        @(negedge core_clk);
        fast_plus = 1'b1;
        rd(SUB_MAXCLK, 4);
        chk(rd_word(), 32'h0000_03E8, "fast plus khz");
        rd(SUB_GUARD, 4);
        chk(rd_word(), 32'hFFFF_FFFF, "guard time absent");
        rd(SUB_BADDR, 1);
        chk({24'h0, rbuf[0]}, {24'h0, FILL_BYTE}, "address register read");
        rd(8'h90, 1);
        chk({24'h0, rbuf[0]}, 32'h0000_00FF, "unmapped read");
    endtask
    task automatic t_length();
        wr2(SUB_DLEN, 16'h0010);
        repeat (20) @(negedge core_clk);
        chk({16'h0, mps}, 32'h0000_00FB, "length applied too early");
        rd(SUB_DLEN, 3);
        chk({8'h0, rbuf[0], rbuf[1], rbuf[2]}, 32'h0000_10FF, "length readback");
        repeat (20) @(negedge core_clk);
        chk({16'h0, mps}, 32'h0000_000B, "packet size at minimum");
        wr2(SUB_DLEN, 16'h0200);
        rd(SUB_DLEN, 2);
        chk({16'h0, rbuf[0], rbuf[1]}, {16'h0, DLEN_MAX_SUP}, "length clipped");
        repeat (20) @(negedge core_clk);
        chk({16'h0, mps}, {16'h0, DLEN_MAX_SUP - 16'h0005}, "packet size clipped");
    endtask
    task automatic t_response_fifo();
        logic [31:0] w;
        @(negedge core_clk);
        cmd_busy = 1'b1;
        for (int i = 0; i < 17; i++)
        begin
            chk({31'h0, tx_ready}, {31'h0, i < 16}, "tx fifo room");
            tx_data = 8'hA0 + 8'(i);
            tx_valid = 1'b1;
            @(negedge core_clk);
        end
        tx_valid = 1'b0;
        rd(SUB_STATE, 4);
        w = rd_word();
        chk({29'h0, w[31:29]}, {29'h0, 2'b11, STRETCH_SUPPORTED}, "state flags");
        chk({16'h0, w[15:0]}, 32'h0000_0010, "response length");
        rd(SUB_DATA, 17);
        for (int i = 0; i < 17; i++)
            chk({24'h0, rbuf[i]}, (i < 16) ? 32'hA0 + 32'(i) : 32'hFF, "drained byte");
        chk({31'h0, tx_ready}, 32'h1, "tx fifo emptied");
    endtask
    task automatic t_receive();
        wr2(SUB_DATA, 16'h5AC3);
        repeat (20) @(negedge core_clk);
        chk({23'h0, rx_valid, rx_data}, 32'h15A, "first rx byte");
        rx_ready = 1'b1;
        @(negedge core_clk);
        chk({23'h0, rx_valid, rx_data}, 32'h1C3, "second rx byte");
        @(negedge core_clk);
        rx_ready = 1'b0;
        chk({31'h0, rx_valid}, 32'h0, "rx fifo emptied");
    endtask
    task automatic t_address();
        logic a0, a1, a2, a3, a4;
        mst.gen_start();
        mst.wr_byte({dev_a, 1'b0}, a0);
        mst.wr_byte(SUB_BADDR, a1);
        mst.wr_byte(8'h80, a2);
        mst.wr_byte(8'h33, a3);
        mst.gen_start();
        mst.wr_byte({dev_a, 1'b0}, a4);
        mst.gen_stop();
        chk({27'h0, a0, a1, a2, a3, a4}, 32'h1F, "old address within access");
        probe(7'h20, 1'b0);
        probe(7'h33, 1'b1);
        pulse_reset();
        probe(7'h33, 1'b1);
        probe(7'h20, 1'b0);
    endtask

    initial
    begin
        rst_n = 1'b0;
        por_n = 1'b0;
        rx_ready = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        cmd_busy = 1'b0;
        fast_plus = 1'b0;
        dev_a = 7'h20;
        mismatches = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (50) @(negedge core_clk);
        rst_n = 1'b1;
        por_n = 1'b1;
        repeat (200) @(negedge core_clk);
        t_reset();
        probe(7'h20, 1'b1);
        t_clock_and_guard();
        t_length();
        t_response_fifo();
        t_receive();
        t_address();
        tally_and_finish();
    end
endmodule
